// File: pkg/fscp_pkg.sv
package fscp_pkg;

    // -------------------------------------------------------------
    // array geometry
    // -------------------------------------------------------------
    localparam int ADDR_W = 26;
    localparam int BLK_W = 10;
    localparam int BLK_LSB = 16;
    localparam logic [10:0] BLK_TOTAL = 11'h400;
    localparam logic [3:0] SIZE_ALL_FROM = 4'hB;

    // -------------------------------------------------------------
    // status_config_second field positions
    // -------------------------------------------------------------
    localparam int SR2_PAUSED = 7;
    localparam int SR2_INVERT = 6;
    localparam int SR2_OTP_HI = 5;
    localparam int SR2_OTP_LO = 3;
    localparam int SR2_QUAD = 1;

    // -------------------------------------------------------------
    // status_config_third field positions
    // -------------------------------------------------------------
    localparam int SR3_DRV_HI = 6;
    localparam int SR3_DRV_LO = 5;
    localparam int SR3_SCHEME = 2;
    localparam int SR3_BOOT_W = 1;
    localparam int SR3_NOW_W = 0;

    // -------------------------------------------------------------
    // factory defaults
    // -------------------------------------------------------------
    localparam logic [1:0] DRV_RST = 2'h3;
    localparam logic [2:0] OTP_RST = 3'h0;
    localparam logic [3:0] SIZE_RST = 4'h0;

    typedef enum {FSCP_INIT, FSCP_RUN} fscp_state_e;

    typedef struct packed {
        logic valid;
        logic sel_third;
        logic nonvol;
        logic [7:0] data;
    } fscp_swr_s;

    typedef struct packed {
        logic valid;
        logic [ADDR_W-1:0] first;
        logic [ADDR_W-1:0] last;
    } fscp_op_s;

endpackage

// File: rtl/fscp_status_protect.sv
`timescale 1ns/1ps
module fscp_status_protect (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_dev_reset,
    // instruction events from the sequencer
    input wire logic i_wr_enable,
    input wire logic i_wr_disable,
    input wire logic i_suspend_done,
    input wire logic i_resume,
    input wire logic i_enter_4b,
    input wire logic i_exit_4b,
    input wire fscp_pkg::fscp_swr_s i_swr,
    input wire fscp_pkg::fscp_op_s i_op,
    input wire logic i_indiv_locked,
    input wire logic i_sec_valid,
    input wire logic [1:0] i_sec_idx,
    // status read back
    output logic [7:0] o_status_second,
    output logic [7:0] o_status_third,
    output logic o_write_latch,
    // command verdicts
    output logic o_op_accept,
    output logic o_op_ignore,
    output logic o_sec_accept,
    output logic o_sec_deny,
    // pin and mode control
    output logic o_lock_preset,
    output logic o_quad_allowed,
    output logic o_pause_pin_en,
    output logic o_addr_4byte,
    output logic [1:0] o_drive_strength
);

    // -------------------------------------------------------------
    // protection decode
    // -------------------------------------------------------------
    // returns {empty, lo, hi} in block units
    function automatic logic [20:0] prot_range(input logic inv, input logic bot,
                                               input logic [3:0] size);
        logic [10:0] n;
        logic [9:0] lo;
        logic [9:0] hi;
        logic empty;
        n = 11'h000;
        lo = 10'h000;
        hi = 10'h3FF;
        empty = 1'b0;
        if (size >= fscp_pkg::SIZE_ALL_FROM) begin
            n = fscp_pkg::BLK_TOTAL;
        end else if (size != 4'h0) begin
            n = 11'(11'h001 << (size - 4'h1));
        end
        if (!inv) begin
            empty = (n == 11'h000);
            if (bot) begin
                hi = 10'(n - 11'h001);
            end else begin
                lo = 10'(fscp_pkg::BLK_TOTAL - n);
            end
        end else begin
            empty = (n == fscp_pkg::BLK_TOTAL);
            if (bot) begin
                lo = n[9:0];
            end else begin
                hi = 10'(fscp_pkg::BLK_TOTAL - n - 11'h001);
            end
        end
        return {empty, lo, hi};
    endfunction

    // -------------------------------------------------------------
    // state
    // -------------------------------------------------------------
    fscp_pkg::fscp_state_e state, next_state;
    logic write_latch_flag, next_wel;
    logic paused_op_flag, next_sus;
    logic [2:0] otp, next_otp;
    logic qe, next_qe;
    logic inv, next_inv;
    logic tb, next_tb;
    logic [3:0] bp, next_bp;
    logic lock_scheme_select, next_wps;
    logic [1:0] drv, next_drv;
    logic boot_addr_width, next_adp;
    logic address_width_now, next_ads;
    logic op_ok, next_op_ok;
    logic op_no, next_op_no;
    logic sec_ok, next_sec_ok;
    logic sec_no, next_sec_no;

    logic [20:0] range;
    logic [9:0] first_blk;
    logic [9:0] last_blk;
    logic overlap;
    logic hit;
    logic swr_take;
    logic running;

    assign range = prot_range(inv, tb, bp);
    assign first_blk = i_op.first[fscp_pkg::BLK_LSB +: fscp_pkg::BLK_W];
    assign last_blk = i_op.last[fscp_pkg::BLK_LSB +: fscp_pkg::BLK_W];
    // both ends are checked so a span crossing into the range is caught
    assign overlap = !range[20] && (first_blk <= range[9:0])
                     && (last_blk >= range[19:10]);
    assign hit = lock_scheme_select ? i_indiv_locked : overlap;
    assign running = (state == fscp_pkg::FSCP_RUN);
    assign swr_take = running && i_swr.valid && write_latch_flag;

    always_comb begin
        next_state = fscp_pkg::FSCP_RUN;
        next_wel = write_latch_flag;
        next_sus = paused_op_flag;
        next_otp = otp;
        next_qe = qe;
        next_inv = inv;
        next_tb = tb;
        next_bp = bp;
        next_wps = lock_scheme_select;
        next_drv = drv;
        next_adp = boot_addr_width;
        next_ads = address_width_now;
        next_op_ok = 1'b0;
        next_op_no = 1'b0;
        next_sec_ok = 1'b0;
        next_sec_no = 1'b0;
        case (state)
            fscp_pkg::FSCP_INIT: begin
                next_ads = boot_addr_width;
            end
            fscp_pkg::FSCP_RUN: begin
                if (i_resume) begin
                    next_sus = 1'b0;
                end
                if (i_suspend_done) begin
                    next_sus = 1'b1;
                end
                if (i_exit_4b) begin
                    next_ads = 1'b0;
                end
                if (i_enter_4b) begin
                    next_ads = 1'b1;
                end
                if (i_wr_disable || swr_take || i_op.valid || i_sec_valid) begin
                    next_wel = 1'b0;
                end
                if (swr_take && !i_swr.sel_third) begin
                    next_inv = i_swr.data[fscp_pkg::SR2_INVERT];
                    next_qe = i_swr.data[fscp_pkg::SR2_QUAD];
                    // otp bits only ever accumulate ones
                    next_otp = otp | i_swr.data[fscp_pkg::SR2_OTP_HI:fscp_pkg::SR2_OTP_LO];
                end
                if (swr_take && i_swr.sel_third) begin
                    next_drv = i_swr.data[fscp_pkg::SR3_DRV_HI:fscp_pkg::SR3_DRV_LO];
                    next_wps = i_swr.data[fscp_pkg::SR3_SCHEME];
                    if (i_swr.nonvol) begin
                        next_adp = i_swr.data[fscp_pkg::SR3_BOOT_W];
                    end
                end
                if (i_op.valid) begin
                    next_op_ok = write_latch_flag && !hit;
                    next_op_no = !(write_latch_flag && !hit);
                end
                if (i_sec_valid) begin
                    next_sec_ok = write_latch_flag && !otp[i_sec_idx];
                    next_sec_no = !(write_latch_flag && !otp[i_sec_idx]);
                end
                if (i_wr_enable) begin
                    next_wel = 1'b1;
                end
                if (i_dev_reset) begin
                    next_state = fscp_pkg::FSCP_INIT;
                    next_wel = 1'b0;
                end
            end
            default: begin
                next_state = fscp_pkg::FSCP_INIT;
            end
        endcase
    end

    // power-up restores factory values; i_dev_reset keeps stored bits
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            state <= fscp_pkg::FSCP_INIT;
            write_latch_flag <= 1'b0;
            paused_op_flag <= 1'b0;
            otp <= fscp_pkg::OTP_RST;
            qe <= 1'b0;
            inv <= 1'b0;
            tb <= 1'b0;
            bp <= fscp_pkg::SIZE_RST;
            lock_scheme_select <= 1'b0;
            drv <= fscp_pkg::DRV_RST;
            boot_addr_width <= 1'b0;
            address_width_now <= 1'b0;
            op_ok <= 1'b0;
            op_no <= 1'b0;
            sec_ok <= 1'b0;
            sec_no <= 1'b0;
        end else begin
            state <= next_state;
            write_latch_flag <= next_wel;
            paused_op_flag <= next_sus;
            otp <= next_otp;
            qe <= next_qe;
            inv <= next_inv;
            tb <= next_tb;
            bp <= next_bp;
            lock_scheme_select <= next_wps;
            drv <= next_drv;
            boot_addr_width <= next_adp;
            address_width_now <= next_ads;
            op_ok <= next_op_ok;
            op_no <= next_op_no;
            sec_ok <= next_sec_ok;
            sec_no <= next_sec_no;
        end
    end

    // -------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------
    // reserved positions read as zero
    always_comb begin
        o_status_second = 8'h00;
        o_status_second[fscp_pkg::SR2_PAUSED] = paused_op_flag;
        o_status_second[fscp_pkg::SR2_INVERT] = inv;
        o_status_second[fscp_pkg::SR2_OTP_HI:fscp_pkg::SR2_OTP_LO] = otp;
        o_status_second[fscp_pkg::SR2_QUAD] = qe;
        o_status_third = 8'h00;
        o_status_third[fscp_pkg::SR3_DRV_HI:fscp_pkg::SR3_DRV_LO] = drv;
        o_status_third[fscp_pkg::SR3_SCHEME] = lock_scheme_select;
        o_status_third[fscp_pkg::SR3_BOOT_W] = boot_addr_width;
        o_status_third[fscp_pkg::SR3_NOW_W] = address_width_now;
    end

    assign o_write_latch = write_latch_flag;
    assign o_op_accept = op_ok;
    assign o_op_ignore = op_no;
    assign o_sec_accept = sec_ok;
    assign o_sec_deny = sec_no;
    assign o_lock_preset = !running;
    assign o_quad_allowed = qe;
    assign o_pause_pin_en = !qe;
    assign o_addr_4byte = address_width_now;
    assign o_drive_strength = drv;

    // -------------------------------------------------------------
    // checks
    // -------------------------------------------------------------
    paused_set_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        running && i_suspend_done && !i_dev_reset |=> o_status_second[fscp_pkg::SR2_PAUSED])
        else $error("paused flag not set after suspend");
    otp_sticky_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        otp != 3'h0 |=> (otp & $past(otp)) == $past(otp))
        else $error("otp lock bit cleared");
    // follows the written bit, so a stuck or swapped quad enable is caught
    quad_pins_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        swr_take && !i_swr.sel_third
        |=> o_quad_allowed == $past(i_swr.data[fscp_pkg::SR2_QUAD])
        && o_pause_pin_en != o_quad_allowed)
        else $error("pause pin and quad mode both on or off");
    boot_width_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        state == fscp_pkg::FSCP_INIT |=> o_addr_4byte == $past(boot_addr_width))
        else $error("address width not loaded from boot bit");
    boot_guard_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        !(swr_take && i_swr.nonvol && i_swr.sel_third) |=> $stable(boot_addr_width))
        else $error("boot width changed without non-volatile write");
    latch_gate_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        running && i_swr.valid && !write_latch_flag && !i_swr.sel_third |=> $stable(inv) && $stable(qe))
        else $error("status write taken without write latch");
    latch_clear_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        swr_take && !i_wr_enable |=> !o_write_latch)
        else $error("write latch not cleared after status write");
    prot_ignore_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        running && i_op.valid && !lock_scheme_select && overlap && !i_dev_reset
        |=> o_op_ignore && !o_op_accept)
        else $error("protected erase or program not ignored");
    // size field is fixed here, so the decode is probed with a large size every cycle
    full_size_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        prot_range(1'b0, tb, bp | fscp_pkg::SIZE_ALL_FROM) == {1'b0, 10'h000, 10'h3FF})
        else $error("large size field does not protect all blocks");

endmodule

// File: verification/flash_status_config_and_protect_tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin num_errors++; \
    $display("FAIL t=%0t got=%h exp=%h", $time, (g), (e)); end end
module flash_status_config_and_protect_tb;
    logic i_clk = 1'b0;
    logic i_resetn = 1'b0;
    logic dev_rst, wr_en, wr_dis, susp, resume, ent4, ext4, locked, sec_v;
    logic [1:0] sec_idx;
    fscp_pkg::fscp_swr_s swr;
    fscp_pkg::fscp_op_s op;
    logic [7:0] st2, st3;
    logic wl, op_acc, op_ign, sec_acc, sec_deny, preset, quad_ok, pause_en, addr4, seen;
    logic [1:0] drive, d, r;
    logic [fscp_pkg::ADDR_W-1:0] a;
    int num_errors = 0;
    int comparisons = 0;

    initial begin
        forever #2 i_clk = ~i_clk;
    end

    fscp_host_model i_fscp_host_model (.i_clk(i_clk), .o_dev_reset(dev_rst),
        .o_wr_enable(wr_en), .o_wr_disable(wr_dis), .o_suspend_done(susp), .o_resume(resume),
        .o_enter_4b(ent4), .o_exit_4b(ext4), .o_swr(swr), .o_op(op),
        .o_indiv_locked(locked), .o_sec_valid(sec_v), .o_sec_idx(sec_idx));

    fscp_status_protect i_fscp_status_protect (.i_clk(i_clk), .i_resetn(i_resetn),
        .i_dev_reset(dev_rst), .i_wr_enable(wr_en), .i_wr_disable(wr_dis),
        .i_suspend_done(susp), .i_resume(resume), .i_enter_4b(ent4), .i_exit_4b(ext4),
        .i_swr(swr), .i_op(op), .i_indiv_locked(locked), .i_sec_valid(sec_v),
        .i_sec_idx(sec_idx), .o_status_second(st2), .o_status_third(st3),
        .o_write_latch(wl), .o_op_accept(op_acc), .o_op_ignore(op_ign),
        .o_sec_accept(sec_acc), .o_sec_deny(sec_deny), .o_lock_preset(preset),
        .o_quad_allowed(quad_ok), .o_pause_pin_en(pause_en), .o_addr_4byte(addr4),
        .o_drive_strength(drive));

    // ---------------------------------------------------------
    // expectations and helpers
    // ---------------------------------------------------------
    // size field sits at its factory zero: plain decode protects nothing, inverted all
    function automatic logic exp_ignore(input logic scheme, input logic inv, input logic lk);
        return scheme ? lk : inv;
    endfunction

    task automatic wrs(input logic sel, input logic nv, input logic [7:0] data);
        i_fscp_host_model.write_status(sel, nv, data, 1'b1);
    endtask

    task automatic op_check(input logic sec, input logic [1:0] idx, input logic lk,
                            input logic ign);
        a = fscp_pkg::ADDR_W'($urandom);
        i_fscp_host_model.request_op(sec, idx, a, a | 26'h000FFFF, lk);
        if (sec) `CHK({sec_acc, sec_deny}, {~ign, ign})
        else `CHK({op_acc, op_ign}, {~ign, ign})
    endtask

    task automatic tally_and_finish();
        $display("comparisons=%0d mismatches=%0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        #20000;
        num_errors++;
        tally_and_finish();
    end

    // ---------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------
    initial begin
        void'($urandom(32'h7d14));
        r = 2'($urandom);
        repeat (6) @(negedge i_clk);
        `CHK(st2 & 8'hFA, 8'h00)
        `CHK(st3 & 8'h67, 8'h60)
        `CHK({preset, pause_en, quad_ok}, 3'b110)
        i_resetn = 1'b1;
        repeat (2) @(negedge i_clk);
        $display("test reset done");
        i_fscp_host_model.write_status(1'b0, 1'b0, 8'h02, 1'b0);
        `CHK(st2 & 8'hFA, 8'h00)
        wrs(1'b0, 1'b0, 8'h02);
        `CHK({st2[1], quad_ok, pause_en, wl}, 4'b1100)
        for (int i = 0; i < 4; i++) begin
            d = 2'(i) ^ r;
            wrs(1'b1, 1'b0, {1'b0, d, 5'h00});
            `CHK({st3[6:5], drive}, {d, d})
        end
        wrs(1'b1, 1'b0, 8'h02);
        `CHK(st3[1], 1'b0)
        wrs(1'b1, 1'b1, 8'h02);
        `CHK(st3[1], 1'b1)
        $display("test status write done");
        i_fscp_host_model.pulse(6'h20);
        seen = 1'b0;
        repeat (3) begin
            seen |= preset;
            @(negedge i_clk);
        end
        `CHK(seen, 1'b1)
        `CHK({addr4, st3[0]}, 2'b11)
        i_fscp_host_model.pulse(6'h01);
        `CHK({addr4, st3[0]}, 2'b00)
        i_fscp_host_model.write_status(1'b0, 1'b0, 8'h00, 1'b1);
        i_fscp_host_model.pulse(6'h12);
        `CHK({addr4, wl}, 2'b10)
        i_fscp_host_model.pulse(6'h08);
        `CHK(st2[7], 1'b1)
        i_fscp_host_model.pulse(6'h04);
        `CHK(st2[7], 1'b0)
        $display("test events done");
        for (int i = 0; i < 4; i++) begin
            wrs(1'b0, 1'b0, {1'b0, i[0], 4'h0, 2'h2});
            wrs(1'b1, 1'b0, {1'b0, 2'h3, 2'h0, i[1], 2'h0});
            for (int k = 0; k < 2; k++) op_check(1'b0, 2'h0, k[0], exp_ignore(i[1], i[0], k[0]));
        end
        $display("test protection done");
        op_check(1'b1, 2'h0, 1'b0, 1'b0);
        wrs(1'b0, 1'b0, 8'h08);
        op_check(1'b1, 2'h0, 1'b0, 1'b1);
        op_check(1'b1, 2'h1, 1'b0, 1'b0);
        wrs(1'b0, 1'b0, 8'h10);
        `CHK(st2[5:3], 3'b011)
        wrs(1'b0, 1'b0, 8'h00);
        `CHK(st2 & 8'hFA, 8'h18)
        $display("test security locks done");
        tally_and_finish();
    end
endmodule

// File: verification/fscp_host_model.sv
`timescale 1ns/1ps
module fscp_host_model (
    // clock
    input wire logic i_clk,
    // instruction events toward the device
    output logic o_dev_reset,
    output logic o_wr_enable,
    output logic o_wr_disable,
    output logic o_suspend_done,
    output logic o_resume,
    output logic o_enter_4b,
    output logic o_exit_4b,
    output fscp_pkg::fscp_swr_s o_swr,
    output fscp_pkg::fscp_op_s o_op,
    output logic o_indiv_locked,
    output logic o_sec_valid,
    output logic [1:0] o_sec_idx
);
    // ---------------------------------------------------------
    // host instruction sequences, launched on the falling edge
    // ---------------------------------------------------------
    initial begin
        {o_dev_reset, o_wr_enable, o_wr_disable, o_suspend_done} = 4'h0;
        {o_resume, o_enter_4b, o_exit_4b, o_indiv_locked, o_sec_valid} = 5'h0;
        o_sec_idx = 2'h0;
        o_swr = '0;
        o_op = '0;
    end

    task automatic pulse(input logic [5:0] sel);
        @(negedge i_clk);
        {o_dev_reset, o_wr_disable, o_suspend_done, o_resume, o_enter_4b, o_exit_4b} = sel;
        @(negedge i_clk);
        {o_dev_reset, o_wr_disable, o_suspend_done, o_resume, o_enter_4b, o_exit_4b} = 6'h0;
    endtask

    // idle payload shows the inverse so a stale value is never mistaken for data
    task automatic write_status(input logic sel, input logic nv, input logic [7:0] data,
                                input logic wren);
        @(negedge i_clk);
        o_wr_enable = wren;
        @(negedge i_clk);
        o_wr_enable = 1'b0;
        o_swr = '{1'b1, sel, nv, data};
        @(negedge i_clk);
        o_swr = '{1'b0, ~sel, ~nv, ~data};
    endtask

    // spans above 128Mb assume the extended address byte was already loaded
    task automatic request_op(input logic sec, input logic [1:0] idx,
                              input logic [fscp_pkg::ADDR_W-1:0] first,
                              input logic [fscp_pkg::ADDR_W-1:0] last, input logic locked);
        @(negedge i_clk);
        o_wr_enable = 1'b1;
        @(negedge i_clk);
        o_wr_enable = 1'b0;
        o_sec_valid = sec;
        o_sec_idx = idx;
        o_op = '{~sec, first, last};
        o_indiv_locked = locked;
        @(negedge i_clk);
        o_sec_valid = 1'b0;
        o_sec_idx = ~idx;
        o_op = '{1'b0, ~first, ~last};
        o_indiv_locked = ~locked;
    endtask
endmodule
